// *** src/tmrc_defs.svh ***
`ifndef TMRC_DEFS_SVH
`define TMRC_DEFS_SVH

// ----------------------------------------------------------------
// Register indices (byte address is four times the index)
// ----------------------------------------------------------------
`define TMRC_IDX_COUNT      6'h01
`define TMRC_IDX_OPTION     6'h02
`define TMRC_IDX_PINDIR     6'h03

// ----------------------------------------------------------------
// Option register fields
// ----------------------------------------------------------------
`define TMRC_OPT_CSS        5
`define TMRC_OPT_SE         4
`define TMRC_OPT_PSA        3
`define TMRC_OPT_RATE_MSB   2
`define TMRC_OPT_RATE_LSB   0

// ----------------------------------------------------------------
// Reset values
// ----------------------------------------------------------------
`define TMRC_RST_COUNT      8'h00
`define TMRC_RST_OPTION     8'hff
`define TMRC_RST_PINDIR     4'hf
`define TMRC_RST_PRESCALE   8'h00

// ----------------------------------------------------------------
// Timing and pin placement
// ----------------------------------------------------------------
`define TMRC_INHIBIT_CYCLES 2'h2
`define TMRC_CLK_PIN_BIT    2
`define TMRC_HSIZE_WORD     3'h2

`endif

// *** src/tmrc_pkg.sv ***
package tmrc_pkg;

    // ----------------------------------------------------------------
    // Quarter phases of one instruction cycle
    // ----------------------------------------------------------------
    typedef enum logic [1:0] {
        ph_q1,
        ph_q2,
        ph_q3,
        ph_q4
    } tmrc_phase_t;

endpackage

// *** src/tmrc_prescaler.sv ***
`timescale 1ns/1ps
`include "tmrc_defs.svh"

module tmrc_prescaler #(
    parameter int WIDTH  = 8,
    parameter int RATE_W = 3
) (
    input  wire logic              ref_clk,
    input  wire logic              resetn,
    input  wire logic              clear,
    input  wire logic              count_event,
    input  wire logic              assigned,
    input  wire logic [RATE_W-1:0] rate,
    input  wire logic              bypass_level,
    output logic                   pre_out
);

    // ----------------------------------------------------------------
    // Divider chain
    // ----------------------------------------------------------------
    logic [WIDTH-1:0] ps_count;  // Hidden from software
    logic [WIDTH-1:0] carry;     // Toggle request per stage

    // Stage zero sees the event only while attached
    assign carry[0] = count_event & assigned;

    // Ripple-style chain: a stage toggles when all lower stages are high
    genvar i;
    for (i = 1; i < WIDTH; i++) begin : g_stage
        assign carry[i] = carry[i-1] & ps_count[i-1];
    end

    always_ff @(posedge ref_clk or negedge resetn) begin
        if (!resetn) begin
            ps_count <= `TMRC_RST_PRESCALE;
        end else if (clear) begin
            ps_count <= `TMRC_RST_PRESCALE;
        end else begin
            ps_count <= ps_count ^ carry;
        end
    end

    // ----------------------------------------------------------------
    // Output select
    // ----------------------------------------------------------------
    // Stage n is high for half of every 2^(n+1) events, so it is symmetric
    always_ff @(posedge ref_clk or negedge resetn) begin
        if (!resetn) begin
            pre_out <= 1'b0;
        end else if (assigned) begin
            // stage n gives divide by 2^(n+1)
            pre_out <= ps_count[rate];
        end else begin
            pre_out <= bypass_level;
        end
    end

    // ----------------------------------------------------------------
    // Checks
    // ----------------------------------------------------------------
    property p_reset_zero;
        @(posedge ref_clk) $rose(resetn) |-> (ps_count == `TMRC_RST_PRESCALE);
    endproperty
    a_reset_zero: assert property (p_reset_zero)
        else $error("prescaler not zero after reset");

    property p_clear;
        @(posedge ref_clk) disable iff (!resetn)
            clear |=> (ps_count == `TMRC_RST_PRESCALE);
    endproperty
    a_clear: assert property (p_clear)
        else $error("prescaler not cleared by count write");

    property p_bypass;
        @(posedge ref_clk) disable iff (!resetn)
            !assigned |=> (pre_out == $past(bypass_level));
    endproperty
    a_bypass: assert property (p_bypass)
        else $error("pin level not passed through");

endmodule

// *** src/tmrc_sync.sv ***
`timescale 1ns/1ps

module tmrc_sync (
    input  wire logic ref_clk,
    input  wire logic resetn,
    input  wire logic level_in,
    input  wire logic sample_q2,
    input  wire logic sample_q4,
    output logic      edge_pulse
);

    // ----------------------------------------------------------------
    // Phase sampler
    // ----------------------------------------------------------------
    logic       s1;       // First stage, read only by s2
    logic       s2;       // Second stage, one sampling phase later
    logic       s2_prev;  // Edge reference
    logic       sample;   // Second or fourth phase
    logic [1:0] fill;     // Sampling phases seen since reset
    logic       primed;   // Both stages hold real samples

    // Sampling twice per instruction cycle catches a level held two clocks
    assign sample = sample_q2 | sample_q4;
    assign primed = (fill == 2'h3);

    // sample on second and fourth phases
    always_ff @(posedge ref_clk or negedge resetn) begin
        if (!resetn) begin
            s1      <= 1'b0;
            s2      <= 1'b0;
            s2_prev <= 1'b0;
            fill    <= 2'h0;
        end else begin
            if (sample) begin
                s1 <= level_in;
                s2 <= s1;
            end
            if (sample && !primed) begin
                fill <= fill + 2'h1;
            end
            s2_prev <= s2;
        end
    end

    // increment request lags the edge
    // Reset zeros are not samples, so the first load of s2 gives no edge
    assign edge_pulse = s2 & ~s2_prev & primed;

    // ----------------------------------------------------------------
    // Checks
    // ----------------------------------------------------------------
    property p_edge_on_phase;
        @(posedge ref_clk) disable iff (!resetn)
            edge_pulse |-> $past(sample_q2 || sample_q4);
    endproperty
    a_edge_on_phase: assert property (p_edge_on_phase)
        else $error("edge not taken at a sampling phase");

    property p_edge_lag;
        @(posedge ref_clk) disable iff (!resetn)
            ($rose(level_in) && !s1 && !s2) |->
                !edge_pulse ##1 !edge_pulse ##1 !edge_pulse;
    endproperty
    a_edge_lag: assert property (p_edge_lag)
        else $error("increment came before synchronisation");

endmodule

// *** src/tmrc_top.sv ***
// The AHB-Lite slave port is this design's own decision.
`timescale 1ns/1ps
`include "tmrc_defs.svh"

// Summary of operation
// - Timer mode counts each instruction cycle
// - Count write blocks increments for next two instruction cycles
// - Counter mode counts external pin edges
// - Edge select: zero rising, one falling
// - Prescaler serves counter or watchdog only
// - Attached prescaler divides two to 256
// - Prescaler count hidden from software access
// - Count write clears attached prescaler
// - Reset leaves prescaler all zeros
// - Unattached: pin passes straight through
// - Sample prescaler output on phases two, four
// - Prescaler output divided and symmetric
// - Increment lags the qualifying edge
// - Clock source bit forces pin input

module tmrc_top
    import tmrc_pkg::*;
(
    input  wire logic        ref_clk,
    input  wire logic        resetn,
    input  wire logic        hsel,
    input  wire logic [31:0] haddr,
    input  wire logic [1:0]  htrans,
    input  wire logic        hwrite,
    input  wire logic [2:0]  hsize,
    input  wire logic [31:0] hwdata,
    input  wire logic        hready,
    output logic      [31:0] hrdata,
    output logic             hreadyout,
    output logic             hresp,
    input  wire logic        ext_clock_pin,
    output logic      [7:0]  count_value,
    output logic      [3:0]  pin_direction_eff
);

    // ----------------------------------------------------------------
    // Instruction cycle phases
    // ----------------------------------------------------------------
    tmrc_phase_t phase;       // Current quarter
    tmrc_phase_t next_phase;  // Following quarter
    logic        at_q2;       // Second phase active
    logic        at_q4;       // Last phase, end of instruction cycle

    // Four clocks make one instruction cycle
    always_comb begin
        case (phase)
            ph_q1:   next_phase = ph_q2;
            ph_q2:   next_phase = ph_q3;
            ph_q3:   next_phase = ph_q4;
            default: next_phase = ph_q1;
        endcase
    end

    // Phase register
    always_ff @(posedge ref_clk or negedge resetn) begin
        if (!resetn) begin
            phase <= ph_q1;
        end else begin
            phase <= next_phase;
        end
    end

    assign at_q2 = (phase == ph_q2);
    assign at_q4 = (phase == ph_q4);

    // ----------------------------------------------------------------
    // Bus slave: address phase decode
    // ----------------------------------------------------------------
    logic       addr_take;   // Valid word transfer in address phase
    logic       in_range;    // Upper address bits zero
    logic       hit_count;   // Count register addressed
    logic       hit_option;  // Option register addressed
    logic       hit_pindir;  // Pin direction register addressed
    logic [7:0] timer_count; // Software visible count
    logic [7:0] read_mux;    // Read value for the addressed word

    // Sub-word transfers are ignored: only whole words are taken
    assign addr_take  = hsel & hready & htrans[1] & (hsize == `TMRC_HSIZE_WORD);
    assign in_range   = (haddr[31:8] == 24'h00_0000) & (haddr[1:0] == 2'h0);
    assign hit_count  = in_range & (haddr[7:2] == `TMRC_IDX_COUNT);
    assign hit_option = in_range & (haddr[7:2] == `TMRC_IDX_OPTION);
    assign hit_pindir = in_range & (haddr[7:2] == `TMRC_IDX_PINDIR);

    // prescaler never on the read path
    // Write-only and unmapped words read as zero
    assign read_mux = hit_count ? timer_count : 8'h00;

    // ----------------------------------------------------------------
    // Bus slave: data phase
    // ----------------------------------------------------------------
    logic wr_count;   // Count write in data phase
    logic wr_option;  // Option write in data phase
    logic wr_pindir;  // Pin direction write in data phase

    // Write intent is held into the data phase where hwdata stands
    always_ff @(posedge ref_clk or negedge resetn) begin
        if (!resetn) begin
            wr_count  <= 1'b0;
            wr_option <= 1'b0;
            wr_pindir <= 1'b0;
        end else begin
            wr_count  <= addr_take & hwrite & hit_count;
            wr_option <= addr_take & hwrite & hit_option;
            wr_pindir <= addr_take & hwrite & hit_pindir;
        end
    end

    // Zero wait states, always OKAY; read data registered at address phase
    always_ff @(posedge ref_clk or negedge resetn) begin
        if (!resetn) begin
            hrdata    <= 32'h0000_0000;
            hreadyout <= 1'b1;
            hresp     <= 1'b0;
        end else begin
            hreadyout <= 1'b1;
            hresp     <= 1'b0;
            if (addr_take && !hwrite) begin
                hrdata <= {24'h00_0000, read_mux};
            end
        end
    end

    // ----------------------------------------------------------------
    // Configuration registers
    // ----------------------------------------------------------------
    logic [7:0] option_config;  // Source, edge, assignment, rate
    logic [3:0] pin_direction;  // Software direction bits
    logic       css;            // Clock source select
    logic       se;             // Source edge select
    logic       prescaler_assign;            // Prescaler to watchdog when set
    logic [2:0] rate;           // Prescale rate field

    // Both registers load from the low data byte
    always_ff @(posedge ref_clk or negedge resetn) begin
        if (!resetn) begin
            option_config <= `TMRC_RST_OPTION;
            pin_direction <= `TMRC_RST_PINDIR;
        end else begin
            if (wr_option) begin
                option_config <= hwdata[7:0];
            end
            if (wr_pindir) begin
                pin_direction <= hwdata[3:0];
            end
        end
    end

    assign css  = option_config[`TMRC_OPT_CSS];
    assign se   = option_config[`TMRC_OPT_SE];
    assign prescaler_assign  = option_config[`TMRC_OPT_PSA];
    assign rate = option_config[`TMRC_OPT_RATE_MSB:`TMRC_OPT_RATE_LSB];

    // ----------------------------------------------------------------
    // Pin direction override
    // ----------------------------------------------------------------
    logic [3:0] pin_force;         // Forced input bit
    logic [3:0] next_pin_dir_eff;  // Effective direction

    assign pin_force        = css ? (4'h1 << `TMRC_CLK_PIN_BIT) : 4'h0;
    assign next_pin_dir_eff = pin_direction | pin_force;

    // Registered so the port comes straight from a flop
    always_ff @(posedge ref_clk or negedge resetn) begin
        if (!resetn) begin
            pin_direction_eff <= `TMRC_RST_PINDIR;
        end else begin
            pin_direction_eff <= next_pin_dir_eff;
        end
    end

    // ----------------------------------------------------------------
    // Pin edge qualification
    // ----------------------------------------------------------------
    logic sel_level;  // Pin, inverted when falling edges count
    logic sel_prev;   // Previous qualified level
    logic sel_armed;  // Reference holds a real pin sample
    logic pin_rise;   // Qualifying edge seen this cycle
    logic ps_event;   // Prescaler input event
    logic ps_clear;   // Prescaler clear request

    assign sel_level = ext_clock_pin ^ se;

    // One flop suffices; no edge until the reference is a real sample
    always_ff @(posedge ref_clk or negedge resetn) begin
        if (!resetn) begin
            sel_prev  <= 1'b0;
            sel_armed <= 1'b0;
        end else begin
            sel_prev  <= sel_level;
            sel_armed <= 1'b1;
        end
    end

    assign pin_rise = sel_level & ~sel_prev & sel_armed;
    assign ps_event = css ? pin_rise : at_q4;
    assign ps_clear = wr_count & ~prescaler_assign;

    // ----------------------------------------------------------------
    // Prescaler and phase synchroniser
    // ----------------------------------------------------------------
    logic pre_out;    // Divided or bypassed source level
    logic sync_edge;  // Synchronised rising edge

    // attached to counter when bit clear
    // eight stages give 1:2 up to 1:256
    tmrc_prescaler #(
        .WIDTH  (8),
        .RATE_W (3)
    ) u_prescaler (
        .ref_clk      (ref_clk),
        .resetn       (resetn),
        .clear        (ps_clear),
        .count_event  (ps_event),
        .assigned     (~prescaler_assign),
        .rate         (rate),
        .bypass_level (sel_level),
        .pre_out      (pre_out)
    );

    tmrc_sync u_sync (
        .ref_clk    (ref_clk),
        .resetn     (resetn),
        .level_in   (pre_out),
        .sample_q2  (at_q2),
        .sample_q4  (at_q4),
        .edge_pulse (sync_edge)
    );

    // ----------------------------------------------------------------
    // Count register and write inhibit
    // ----------------------------------------------------------------
    logic [1:0] inhibit_cnt;  // Instruction cycles still blocked
    logic       inc_req;      // Increment wanted
    logic       inc_ok;       // Increment allowed

    // otherwise wait for the synchronised edge
    assign inc_req = (css | ~prescaler_assign) ? sync_edge : at_q4;
    assign inc_ok  = inc_req & (inhibit_cnt == 2'h0);

    always_ff @(posedge ref_clk or negedge resetn) begin
        if (!resetn) begin
            inhibit_cnt <= 2'h0;
        end else if (wr_count) begin
            inhibit_cnt <= `TMRC_INHIBIT_CYCLES;
        end else if (at_q4 && inhibit_cnt != 2'h0) begin
            inhibit_cnt <= inhibit_cnt - 2'h1;
        end
    end

    // Write wins over a same-cycle increment; a lost tick is part of the block
    always_ff @(posedge ref_clk or negedge resetn) begin
        if (!resetn) begin
            timer_count <= `TMRC_RST_COUNT;
        end else if (wr_count) begin
            timer_count <= hwdata[7:0];
        end else if (inc_ok) begin
            timer_count <= timer_count + 8'h01;
        end
    end
    assign count_value = timer_count;

    // ----------------------------------------------------------------
    // Checks
    // ----------------------------------------------------------------
    default clocking cb @(posedge ref_clk); endclocking
    default disable iff (!resetn);

    property p_timer_step;
        (!css && prescaler_assign && at_q4 && inhibit_cnt == 2'h0 && !wr_count)
            |=> (timer_count == $past(timer_count) + 8'h01);
    endproperty
    a_timer_step: assert property (p_timer_step)
        else $error("timer mode missed an instruction cycle");

    sequence s_count_loaded;
        (timer_count == $past(hwdata[7:0])) && (inhibit_cnt == 2'h2);
    endsequence
    property p_inhibit_load;
        wr_count |=> s_count_loaded;
    endproperty
    a_inhibit_load: assert property (p_inhibit_load)
        else $error("count write not loaded with inhibit");

    property p_inhibit_hold;
        (inhibit_cnt != 2'h0 && !wr_count) |=> $stable(timer_count);
    endproperty
    a_inhibit_hold: assert property (p_inhibit_hold)
        else $error("count moved during write inhibit");

    property p_ext_only;
        (css && !sync_edge && !wr_count) |=> $stable(timer_count);
    endproperty
    a_ext_only: assert property (p_ext_only)
        else $error("counter mode moved without pin edge");

    property p_edge_select;
        (css && $stable(se)) |-> (ps_event == (se ? $fell(ext_clock_pin)
                                                  : $rose(ext_clock_pin)));
    endproperty
    a_edge_select: assert property (p_edge_select)
        else $error("wrong pin edge counted");

    property p_psa_route;
        (!css && !prescaler_assign && at_q4 && !sync_edge && !wr_count) |=> $stable(timer_count);
    endproperty
    a_psa_route: assert property (p_psa_route)
        else $error("attached prescaler bypassed in timer mode");

    property p_wrap;
        (timer_count == 8'hff && inc_ok && !wr_count) |=> (timer_count == 8'h00);
    endproperty
    a_wrap: assert property (p_wrap)
        else $error("count did not wrap to zero");

    property p_pin_override;
        $past(css) |-> pin_direction_eff[`TMRC_CLK_PIN_BIT];
    endproperty
    a_pin_override: assert property (p_pin_override)
        else $error("clock pin not forced to input");

endmodule

// *** verification/tmrc_clk_src.sv ***
`timescale 1ns/1ps

// ------------------------------------------
// Pin clock source, still between runs
// ------------------------------------------
module tmrc_clk_src (
    input  wire logic       ref_clk,
    input  wire logic       go,
    input  wire logic [7:0] n_edges,
    input  wire logic [3:0] half_cyc,
    output logic            pin,
    output logic            busy
);
    logic [7:0] left;  // Edges still to make
    logic [3:0] held;  // Clocks spent at this level

    initial begin
        pin = 1'b0;
        busy = 1'b0;
    end

    always @(posedge ref_clk) begin
        if (!busy) begin
            busy <= go;
            left <= n_edges;
            held <= 4'h1;
        end else if (held != half_cyc) begin
            held <= held + 4'h1;
        end else begin
            // Toggle; the run ends on the last edge
            pin <= ~pin;
            held <= 4'h1;
            left <= left - 8'h01;
            busy <= (left != 8'h01);
        end
    end
endmodule

// *** verification/tb_top.sv ***
`timescale 1ns/1ps
`include "tmrc_defs.svh"

module tb_top;
    localparam logic [31:0] A_CNT = {24'h00_0000, `TMRC_IDX_COUNT, 2'b00};
    localparam logic [31:0] A_OPT = {24'h00_0000, `TMRC_IDX_OPTION, 2'b00};
    localparam logic [31:0] A_DIR = {24'h00_0000, `TMRC_IDX_PINDIR, 2'b00};
    logic        ref_clk;
    logic        resetn;
    logic        hsel;
    logic [31:0] haddr;
    logic [1:0]  htrans;
    logic        hwrite;
    logic [2:0]  hsize;
    logic [31:0] hwdata;
    logic [31:0] hrdata;
    logic        hreadyout;
    logic        hresp;
    logic        ext_clock_pin;
    logic [7:0]  count_value;
    logic [3:0]  pin_direction_eff;
    logic        go;        // Start a source run
    logic [7:0]  n_edges;   // Pin edges per run
    logic [3:0]  half_cyc;  // Clocks per pin level
    logic        busy;      // Source run in progress
    logic        lvl;       // Pin level left by the source
    logic        rd_due;    // Read data phase this cycle
    logic [7:0]  v;
    logic [7:0]  e;
    logic [31:0] exp_q[$];  // Expected read data, oldest first
    int          err_count;
    int          compares;
    int          p;

    tmrc_top dut (
        .ref_clk           (ref_clk),
        .resetn            (resetn),
        .hsel              (hsel),
        .haddr             (haddr),
        .htrans            (htrans),
        .hwrite            (hwrite),
        .hsize             (hsize),
        .hwdata            (hwdata),
        .hready            (hreadyout),
        .hrdata            (hrdata),
        .hreadyout         (hreadyout),
        .hresp             (hresp),
        .ext_clock_pin     (ext_clock_pin),
        .count_value       (count_value),
        .pin_direction_eff (pin_direction_eff)
    );

    tmrc_clk_src src (
        .ref_clk  (ref_clk),
        .go       (go),
        .n_edges  (n_edges),
        .half_cyc (half_cyc),
        .pin      (ext_clock_pin),
        .busy     (busy)
    );

    always #20 ref_clk = ~ref_clk;

    task automatic close_out;
        if (err_count == 0 && compares > 0) begin
            $display("Run complete: PASS");
        end else begin
            $display("Run complete: FAIL");
        end
        $finish;
    endtask

    task automatic check(input string what, input logic [31:0] seen, input logic [31:0] want);
        compares++;
        if (seen !== want) begin
            err_count++;
            $display("Error %s expected %h seen %h", what, want, seen);
        end
    endtask

    // Bounded wait for hready high at an edge
    task automatic wait_rdy;
        int n;
        n = 0;
        do begin
            @(posedge ref_clk);
            n++;
        end while (hreadyout !== 1'b1 && n < 16);
        if (n >= 16) begin
            err_count++;
            close_out();
        end
    endtask

    task automatic bus_wr(input logic [31:0] a, input logic [31:0] d);
        htrans <= 2'b10;
        hwrite <= 1'b1;
        haddr <= a;
        wait_rdy();
        htrans <= 2'b00;
        hwdata <= d;
        wait_rdy();
    endtask

    // Note the expectation; the watcher compares it
    task automatic bus_rd(input logic [31:0] a, input logic [31:0] want);
        htrans <= 2'b10;
        hwrite <= 1'b0;
        haddr <= a;
        wait_rdy();
        htrans <= 2'b00;
        exp_q.push_back(want);
        wait_rdy();
    endtask

    // Write v, read it held, then one tick, then ten more
    task automatic wr_then_rd(input logic [7:0] d);
        bus_wr(A_CNT, {24'h00_0000, d});
        repeat (2) @(posedge ref_clk);
        bus_rd(A_CNT, {24'h00_0000, d});
        repeat (8) @(posedge ref_clk);
        bus_rd(A_CNT, {24'h00_0000, d + 8'h01});
        repeat (38) @(posedge ref_clk);
        bus_rd(A_CNT, {24'h00_0000, d + 8'h0b});
    endtask

    // Count changes of the count over a window
    task automatic count_ticks(input int cyc, input int want);
        logic [7:0] prev;
        int         k;
        prev = count_value;
        k = 0;
        repeat (cyc) begin
            @(posedge ref_clk);
            if (count_value !== prev) begin
                k++;
            end
            prev = count_value;
        end
        check("ticks", k, want);
    endtask

    // Qualifying edges in a run of toggles from level q
    function automatic logic [7:0] quals(input logic q, input logic [7:0] n);
        return q ? (n >> 1) : ((n + 8'h01) >> 1);
    endfunction

    // Counter mode run; settle gaps avoid option glitches
    task automatic ext_run(input logic [7:0] opt, input logic [7:0] n, input logic [7:0] want);
        int w;
        bus_wr(A_OPT, {24'h00_0000, opt});
        repeat (12) @(posedge ref_clk);
        bus_wr(A_CNT, 32'h0000_0000);
        repeat (12) @(posedge ref_clk);
        go <= 1'b1;
        n_edges <= n;
        @(posedge ref_clk);
        go <= 1'b0;
        w = 0;
        do begin
            @(posedge ref_clk);
            w++;
        end while (busy && w < 400);
        if (w >= 400) begin
            err_count++;
            close_out();
        end
        lvl = lvl ^ n[0];
        repeat (20) @(posedge ref_clk);
        bus_rd(A_CNT, {24'h00_0000, want});
    endtask

    // Watcher: one note popped per read data phase
    always @(posedge ref_clk) begin
        if (rd_due) begin
            if (exp_q.size() == 0) begin
                err_count++;
                $display("Error hrdata expected none seen %h", hrdata);
            end else begin
                check("hrdata", hrdata, exp_q.pop_front());
            end
            check("hresp", {31'h0000_0000, hresp}, 32'h0000_0000);
        end
        rd_due = hsel && htrans[1] && !hwrite && hreadyout;
    end

    initial begin
        repeat (60000) @(posedge ref_clk);
        err_count++;
        close_out();
    end

    initial begin
        ref_clk = 1'b0;
        resetn = 1'b0;
        hsel = 1'b1;
        haddr = 32'h0000_0000;
        htrans = 2'b00;
        hwrite = 1'b0;
        hsize = `TMRC_HSIZE_WORD;
        hwdata = 32'h0000_0000;
        go = 1'b0;
        n_edges = 8'h01;
        half_cyc = 4'h3;
        lvl = 1'b0;
        rd_due = 1'b0;
        err_count = 0;
        compares = 0;
        void'($urandom(32'hf565_d580));
        repeat (8) @(posedge ref_clk);
        resetn <= 1'b1;
        @(posedge ref_clk);
        check("dir_eff", {28'h000_0000, pin_direction_eff}, 32'h0000_000f);
        bus_rd(A_CNT, 32'h0000_0000);
        bus_rd(A_OPT, 32'h0000_0000);
        bus_rd(32'h0000_0040, 32'h0000_0000);
        bus_wr(A_OPT, 32'h0000_0008);
        bus_wr(A_DIR, 32'h0000_0000);
        repeat (2) @(posedge ref_clk);
        check("dir_eff", {28'h000_0000, pin_direction_eff}, 32'h0000_0000);
        v = 8'($urandom);
        wr_then_rd(v);
        wr_then_rd(8'hff);
        for (int n = 0; n < 8; n++) begin
            p = 8 << n;
            bus_wr(A_OPT, {29'h0000_0000, 3'(n)});
            bus_wr(A_CNT, 32'h0000_0000);
            repeat (3 * p) @(posedge ref_clk);
            count_ticks(2 * p, 2);
        end
        e = 8'(3 + $urandom % 10);
        ext_run(8'h28, e, quals(lvl, e));
        check("dir_eff", {28'h000_0000, pin_direction_eff}, 32'h0000_0004);
        e = 8'(3 + $urandom % 10);
        ext_run(8'h38, e, quals(~lvl, e));
        ext_run(8'h21, 8'h10 + {7'h00, lvl}, 8'h02);
        close_out();
    end
endmodule
